// ==== design/lcce_core.v ====
// Purpose: Execution core for bitwise AND, AND-inverted, jump-and-store-return,
//          the clock-mode hub write, with its own register memory
// Assumes: Wishbone classic slave, 32-bit data, registered ack
// Notes: Bus writes to memory, PC and flags take effect only while halted
//
// Notes on behaviour
// - Opcode 011000 forms destination AND source as the result.
// - Source is register at s-field, or zero-extended 9-bit s-field if immediate.
// - Opcode 011001 ANDs destination with the inverted source.
// - Zero effect on bitwise ops sets Z when the 32-bit result is zero.
// - Carry effect on bitwise ops loads C with odd parity of result.
// - Result is written back only when the result-write bit is set.
// - Call writes next address into bits 8:0, keeping bits 31:9.
// - Call then loads PC with the 9-bit immediate target from s-field.
// - Call decodes as opcode 010111 with flags 0011, target from s-field.
// - Call carry effect sets C unless return address wraps to zero.
// - No return stack; each call overwrites the single return location.
// - Return is a plain jump to its own word's s-field.
// - No-result effect on a call skips the store and only jumps.
// - Clock-mode op moves low 8 bits of d-field register to clock mode.
// - Clock-mode op is hub opcode 000011, flags 0001, immediate source zero.
// - Clock-mode op completes in 7 to 22 clocks, per hub window.
`timescale 1ns/1ps
`default_nettype none
`include "lcce_defines.vh"

module lcce_core #(
	parameter HUB_SLOT = 4'h0,
	parameter MEM_WORDS = 512
) (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [11:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	output wire [7:0] CLK_MODE,
	output wire CLK_MODE_STB,
	output wire BUSY
);
	// ============================================================
	// States
	localparam ST_HALT = 3'h0;
	localparam ST_FETCH = 3'h1;
	localparam ST_OPER = 3'h2;
	localparam ST_EXEC = 3'h3;
	localparam ST_HUB = 3'h4;
	localparam ST_XFR = 3'h5;
	// Last transfer count, one below the phase length, cut to the counter width on load
	localparam [31:0] XFR_LAST = `LCCE_HUB_XFR_CLK - 1;

	reg [31:0] mem [0:MEM_WORDS-1];
	reg [2:0] state_q, state_d;
	reg [8:0] pc_q, pc_d;
	reg [31:0] ir_q, d_q, s_q;
	reg z_q, z_d, c_q, c_d;
	reg run_q, step_q;
	reg [7:0] clkmode_q;
	reg clkmode_stb_q;
	reg [3:0] hub_slot_q;
	reg [2:0] xfr_cnt_q;
	reg ack_q;
	reg [31:0] dat_q;
	reg core_we;
	reg [31:0] core_wdat;
	reg [31:0] rd_mux;

	wire [5:0] op;
	wire zeff, ceff, reff, imm;
	wire [8:0] dst, src, pc_inc;
	wire [31:0] bw_res;
	wire bw_zero, bw_par;
	wire is_bitwise, is_jump_store_return_op, is_clkmode;
	wire wb_req, wb_wr, halted;
	wire [31:0] ram_rd;

	// ============================================================
	// Field decode
	assign op = ir_q[`LCCE_F_OP_HI:`LCCE_F_OP_LO];
	assign zeff = ir_q[`LCCE_F_ZEFF];
	assign ceff = ir_q[`LCCE_F_CEFF];
	assign reff = ir_q[`LCCE_F_REFF];
	assign imm = ir_q[`LCCE_F_IMM];
	assign dst = ir_q[`LCCE_F_DST_HI:`LCCE_F_DST_LO];
	assign src = ir_q[`LCCE_F_SRC_HI:`LCCE_F_SRC_LO];
	// Wraps within 9 bits, so the top word returns to zero
	assign pc_inc = pc_q + 9'h001;

	assign is_bitwise = (op == `LCCE_OP_AND) || (op == `LCCE_OP_AND_INV);
	// Every jump-and-store variant shares one path; call is its R=1, I=1 form
	assign is_jump_store_return_op = (op == `LCCE_OP_JUMP_RET);
	// Zero immediate source selects the clock-mode hub operation
	assign is_clkmode = (op == `LCCE_OP_HUB) && imm &&
		(src == `LCCE_HUB_SEL_CLKMODE);

	assign halted = (state_q == ST_HALT);
	assign wb_req = WB_CYC_I & WB_STB_I;
	// Writes land on the edge where ack is seen high
	assign wb_wr = wb_req & WB_WE_I & ack_q;

	// ============================================================
	// Bitwise unit
	lcce_bitwise #(
		.WIDTH(32)
	) u_bitwise (
		.invert_src(op == `LCCE_OP_AND_INV),
		.dst_val(d_q),
		.src_val(s_q),
		.result(bw_res),
		.is_zero(bw_zero),
		.odd_parity(bw_par)
	);

	// ============================================================
	// Execute step: writeback, flags, next PC
	always @* begin
		core_we = 1'b0;
		core_wdat = d_q;
		z_d = z_q;
		c_d = c_q;
		pc_d = pc_inc;
		if (state_q == ST_EXEC) begin
			if (is_bitwise) begin
				core_wdat = bw_res;
				core_we = reff;
				if (zeff) begin
					z_d = bw_zero;
				end
				if (ceff) begin
					c_d = bw_par;
				end
			end else if (is_jump_store_return_op) begin
				// Single return slot, overwritten by each call
				core_wdat = {d_q[31:9], pc_inc};
				core_we = reff;
				pc_d = s_q[8:0];
				if (zeff) begin
					z_d = ~|core_wdat;
				end
				if (ceff) begin
					c_d = (pc_inc != 9'h000);
				end
			end
		end
	end

	// ============================================================
	// Sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_HALT: begin
				if (run_q | step_q) begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				state_d = ST_OPER;
			end
			ST_OPER: begin
				state_d = ST_EXEC;
			end
			ST_EXEC: begin
				if (is_clkmode) begin
					state_d = ST_HUB;
				end else begin
					state_d = run_q ? ST_FETCH : ST_HALT;
				end
			end
			ST_HUB: begin
				// Wait for this core's turn at the hub
				if (hub_slot_q == HUB_SLOT) begin
					state_d = ST_XFR;
				end
			end
			ST_XFR: begin
				if (xfr_cnt_q == 3'h0) begin
					state_d = run_q ? ST_FETCH : ST_HALT;
				end
			end
			default: begin
				state_d = ST_HALT;
			end
		endcase
	end

	// ============================================================
	// Core registers
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= ST_HALT;
			pc_q <= `LCCE_PC_RST;
			ir_q <= 32'h00000000;
			d_q <= 32'h00000000;
			s_q <= 32'h00000000;
			z_q <= 1'b0;
			c_q <= 1'b0;
			xfr_cnt_q <= 3'h0;
			clkmode_q <= `LCCE_CLKMODE_RST;
			clkmode_stb_q <= 1'b0;
			hub_slot_q <= 4'h0;
		end else begin
			state_q <= state_d;
			clkmode_stb_q <= 1'b0;
			// Hub rotation free-runs, one slot per clock
			hub_slot_q <= hub_slot_q + 4'h1;
			if (state_q == ST_FETCH) begin
				ir_q <= mem[pc_q];
			end
			if (state_q == ST_OPER) begin
				d_q <= mem[dst];
				s_q <= imm ? {23'h000000, src} : mem[src];
			end
			if (state_q == ST_EXEC) begin
				z_q <= z_d;
				c_q <= c_d;
				xfr_cnt_q <= XFR_LAST[2:0];
				if (!is_clkmode) begin
					pc_q <= pc_d;
				end
			end else if (state_q == ST_XFR) begin
				xfr_cnt_q <= xfr_cnt_q - 3'h1;
				if (xfr_cnt_q == 3'h0) begin
					clkmode_q <= d_q[7:0];
					clkmode_stb_q <= 1'b1;
					pc_q <= pc_inc;
				end
			end else if (halted && wb_wr && WB_ADR_I == `LCCE_ADR_PC) begin
				if (WB_SEL_I[0]) begin
					pc_q[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					pc_q[8] <= WB_DAT_I[8];
				end
			end else if (halted && wb_wr && WB_ADR_I == `LCCE_ADR_FLAGS &&
				WB_SEL_I[0]) begin
				z_q <= WB_DAT_I[`LCCE_FLAGS_Z];
				c_q <= WB_DAT_I[`LCCE_FLAGS_C];
			end
		end
	end

	// ============================================================
	// Control: run level and single-step request
	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			run_q <= 1'b0;
			step_q <= 1'b0;
		end else begin
			if (wb_wr && WB_ADR_I == `LCCE_ADR_CTRL && WB_SEL_I[0]) begin
				run_q <= WB_DAT_I[`LCCE_CTRL_RUN];
			end
			// A new step request outranks the consume of the old one
			if (wb_wr && WB_ADR_I == `LCCE_ADR_CTRL && WB_SEL_I[0] &&
				WB_DAT_I[`LCCE_CTRL_STEP]) begin
				step_q <= 1'b1;
			end else if (halted) begin
				step_q <= 1'b0;
			end
		end
	end

	// ============================================================
	// Register memory; core writes while running, bus only when halted
	function [31:0] merge_bytes;
		input [31:0] old_w;
		input [31:0] new_w;
		input [3:0] sel;
		integer i;
		begin
			merge_bytes = old_w;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					merge_bytes[i*8 +: 8] = new_w[i*8 +: 8];
				end
			end
		end
	endfunction

	assign ram_rd = mem[WB_ADR_I[10:2]];

	always @(posedge CLK_SYS) begin
		if (core_we) begin
			mem[dst] <= core_wdat;
		end else if (halted && wb_wr && WB_ADR_I[`LCCE_ADR_RAM_BIT]) begin
			mem[WB_ADR_I[10:2]] <= merge_bytes(ram_rd, WB_DAT_I, WB_SEL_I);
		end
	end

	// ============================================================
	// Wishbone slave: ack one cycle after request, read data registered
	always @* begin
		rd_mux = 32'h00000000;
		if (WB_ADR_I[`LCCE_ADR_RAM_BIT]) begin
			rd_mux = ram_rd;
		end else begin
			case (WB_ADR_I)
				`LCCE_ADR_CTRL: begin
					rd_mux[`LCCE_CTRL_RUN] = run_q;
				end
				`LCCE_ADR_PC: begin
					rd_mux[8:0] = pc_q;
				end
				`LCCE_ADR_FLAGS: begin
					rd_mux[`LCCE_FLAGS_Z] = z_q;
					rd_mux[`LCCE_FLAGS_C] = c_q;
				end
				`LCCE_ADR_STATUS: begin
					rd_mux[`LCCE_STATUS_BUSY] = ~halted;
					rd_mux[`LCCE_STATUS_HUB] = (state_q == ST_HUB) ||
						(state_q == ST_XFR);
				end
				`LCCE_ADR_CLKMODE: begin
					rd_mux[7:0] = clkmode_q;
				end
				default: begin
					rd_mux = 32'h00000000;
				end
			endcase
		end
	end

	always @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= wb_req & ~ack_q;
			if (wb_req && !ack_q && !WB_WE_I) begin
				dat_q <= rd_mux;
			end
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign CLK_MODE = clkmode_q;
	assign CLK_MODE_STB = clkmode_stb_q;
	assign BUSY = ~halted;
endmodule // lcce_core

`default_nettype wire

// ==== design/lcce_defines.vh ====
// Purpose: Shared constants of the bitwise, call and clock-mode execution core
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef LCCE_DEFINES_VH
`define LCCE_DEFINES_VH

// ============================================================
// Instruction word fields
`define LCCE_F_OP_HI 31
`define LCCE_F_OP_LO 26
`define LCCE_F_ZEFF 25
`define LCCE_F_CEFF 24
`define LCCE_F_REFF 23
`define LCCE_F_IMM 22
`define LCCE_F_DST_HI 17
`define LCCE_F_DST_LO 9
`define LCCE_F_SRC_HI 8
`define LCCE_F_SRC_LO 0

// ============================================================
// Opcodes and selectors
`define LCCE_OP_AND 6'h18
`define LCCE_OP_AND_INV 6'h19
`define LCCE_OP_JUMP_RET 6'h17
`define LCCE_OP_HUB 6'h03
`define LCCE_HUB_SEL_CLKMODE 9'h000

// ============================================================
// Register offsets (byte addresses)
`define LCCE_ADR_CTRL 12'h000
`define LCCE_ADR_PC 12'h004
`define LCCE_ADR_FLAGS 12'h008
`define LCCE_ADR_STATUS 12'h00C
`define LCCE_ADR_CLKMODE 12'h010
`define LCCE_ADR_RAM_BIT 11

// ============================================================
// Field positions
`define LCCE_CTRL_RUN 0
`define LCCE_CTRL_STEP 1
`define LCCE_FLAGS_Z 0
`define LCCE_FLAGS_C 1
`define LCCE_STATUS_BUSY 0
`define LCCE_STATUS_HUB 1

// ============================================================
// Reset values
`define LCCE_PC_RST 9'h000
`define LCCE_CLKMODE_RST 8'h00

// ============================================================
// Timing, in system clocks
`define LCCE_HUB_MIN_CLK 7
`define LCCE_HUB_MAX_CLK 22
`define LCCE_HUB_PERIOD (`LCCE_HUB_MAX_CLK - `LCCE_HUB_MIN_CLK + 1)
`define LCCE_HUB_XFR_CLK (`LCCE_HUB_MIN_CLK - 4)

`endif

// ==== design/lcce_bitwise.v ====
// Purpose: Bitwise AND / AND-with-inverted-source with zero and parity
// Assumes: Purely combinational, used inside lcce_core
// Notes: Parity is 1 for an odd count of ones
`timescale 1ns/1ps
`default_nettype none

module lcce_bitwise #(
	parameter WIDTH = 32
) (
	input wire invert_src,
	input wire [WIDTH-1:0] dst_val,
	input wire [WIDTH-1:0] src_val,
	output wire [WIDTH-1:0] result,
	output wire is_zero,
	output wire odd_parity
);
	wire [WIDTH-1:0] src_eff;

	assign src_eff = invert_src ? ~src_val : src_val;
	assign result = dst_val & src_eff;
	assign is_zero = ~|result;
	assign odd_parity = ^result;
endmodule // lcce_bitwise

`default_nettype wire

// ==== design/unused_placeholder_never.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== test/lcce_core_monitor.sv ====
// Purpose: Port-level checks of the execution core
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every lcce_core instance
`timescale 1ns/1ps
`default_nettype none
`include "lcce_defines.vh"

module lcce_core_monitor (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic [7:0] CLK_MODE,
	input wire logic CLK_MODE_STB,
	input wire logic BUSY
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);

	wire logic req = WB_CYC_I && WB_STB_I;
	wire logic rd_ack = WB_ACK_O && !WB_WE_I;

	// ============================================================
	// Bus answer
	a_ack_next: assert property (req && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing after request");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (WB_ACK_O |-> $past(req))
		else $error("ack without request");
	a_unmapped_zero: assert property (rd_ack && WB_ADR_I == 12'h014
		|-> WB_DAT_O == 32'h00000000)
		else $error("unmapped read not zero");
	a_pc_width: assert property (rd_ack && WB_ADR_I == `LCCE_ADR_PC
		|-> WB_DAT_O[31:9] == 23'h000000)
		else $error("pc wider than nine bits");

	// ============================================================
	// Clock-mode transfer
	a_mode_read: assert property (rd_ack && WB_ADR_I == `LCCE_ADR_CLKMODE
		|-> WB_DAT_O == {24'h000000, CLK_MODE})
		else $error("clock mode readback differs");
	a_mode_strobe: assert property (CLK_MODE != $past(CLK_MODE) |-> CLK_MODE_STB)
		else $error("clock mode changed without strobe");
	a_stb_pulse: assert property (CLK_MODE_STB |=> !CLK_MODE_STB)
		else $error("strobe longer than one cycle");
	a_hub_span: assert property (CLK_MODE_STB |-> $past(BUSY, 7))
		else $error("hub write shorter than minimum");
endmodule // lcce_core_monitor

bind lcce_core lcce_core_monitor u_lcce_core_monitor (.CLK_SYS(CLK_SYS),
	.ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.CLK_MODE(CLK_MODE), .CLK_MODE_STB(CLK_MODE_STB), .BUSY(BUSY));

`default_nettype wire

// ==== test/lcce_hub_model.sv ====
// Purpose: Shared hub holding the system clock-mode register
// Assumes: Takes the mode on each strobe from the core
// Notes: Counts writes so extra strobes show up
`timescale 1ns/1ps
`default_nettype none

module lcce_hub_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] mode,
	input wire logic mode_stb,
	output logic [7:0] hub_mode_q,
	output logic [7:0] n_writes_q
);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hub_mode_q <= 8'h00;
			n_writes_q <= 8'h00;
		end else if (mode_stb) begin
			hub_mode_q <= mode;
			n_writes_q <= n_writes_q + 8'h01;
		end
	end
endmodule // lcce_hub_model

`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench of the execution core
// Assumes: Core halted between single steps
// Notes: Programs are loaded and inspected over the bus
`timescale 1ns/1ps
`default_nettype none
`include "lcce_defines.vh"

module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h00000000;
	wire logic [31:0] rdat;
	wire logic ack;
	wire logic [7:0] mode;
	wire logic mode_stb;
	wire logic busy;
	wire logic [7:0] hub_mode;
	wire logic [7:0] hub_n;
	logic [31:0] rv;
	int fails = 0;
	int n_compared = 0;
	int busy_cycles = 0;

	always #20 clk = ~clk;

	lcce_core u_lcce_core (.CLK_SYS(clk), .ARST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.CLK_MODE(mode), .CLK_MODE_STB(mode_stb), .BUSY(busy));
	lcce_hub_model u_hub (.clk(clk), .rst_n(rst_n), .mode(mode),
		.mode_stb(mode_stb), .hub_mode_q(hub_mode), .n_writes_q(hub_n));

	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// ============================================================
	// Bus and program helpers
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (i >= 50) begin
			fails++;
			tally_and_finish();
		end
		rv = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input string what, input logic [11:0] a,
		input logic [31:0] e);
		wb(1'b0, a, 32'h00000000);
		chk(what, e, rv);
	endtask

	function automatic logic [11:0] mem(input logic [8:0] i);
		return {1'b1, i, 2'b00};
	endfunction

	function automatic logic [31:0] ins(input logic [5:0] op,
		input logic [3:0] zcri, input logic [8:0] d, input logic [8:0] s);
		return {op, zcri, 4'hF, d, s};
	endfunction

	// Runs one instruction; the core halts by itself after a step
	task automatic step(input logic [8:0] pc);
		int i;
		wb(1'b1, `LCCE_ADR_PC, {23'h000000, pc});
		wb(1'b1, `LCCE_ADR_CTRL, 32'h00000002);
		repeat (2) @(posedge clk);
		i = 0;
		while (busy !== 1'b0 && i < 40) begin
			@(posedge clk);
			i++;
		end
		// Edges seen with the core busy, one per instruction clock
		busy_cycles = i;
		if (i >= 40) begin
			fails++;
			tally_and_finish();
		end
	endtask

	// ============================================================
	// Scenarios
	task automatic sc_and();
		wb(1'b1, mem(9'h1), 32'h0000000A);
		wb(1'b1, mem(9'h2), 32'h00000007);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND, 4'hE, 9'h1, 9'h2));
		step(9'h0);
		rd("and reg", mem(9'h1), 32'h00000002);
		rd("and flags", `LCCE_ADR_FLAGS, 32'h00000002);
		wb(1'b1, mem(9'h1), 32'h0000000A);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND, 4'hF, 9'h1, 9'h5));
		step(9'h0);
		rd("and imm", mem(9'h1), 32'h00000000);
		rd("and zero", `LCCE_ADR_FLAGS, 32'h00000001);
		wb(1'b1, mem(9'h1), 32'h0000000A);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND, 4'hF, 9'h1, 9'hF));
		step(9'h0);
		rd("and keep", mem(9'h1), 32'h0000000A);
		rd("flags clr", `LCCE_ADR_FLAGS, 32'h00000000);
		rd("unmapped", 12'h014, 32'h00000000);
	endtask

	task automatic sc_and_inverted_op();
		wb(1'b1, mem(9'h1), 32'hF731125A);
		wb(1'b1, mem(9'h2), 32'hFFFFFFF8);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND_INV, 4'hE, 9'h1, 9'h2));
		step(9'h0);
		rd("and_inverted_op reg", mem(9'h1), 32'h00000002);
		rd("and_inverted_op flags", `LCCE_ADR_FLAGS, 32'h00000002);
		wb(1'b1, mem(9'h2), 32'hFFFFFFFA);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND_INV, 4'h2, 9'h1, 9'h2));
		step(9'h0);
		rd("and_inverted_op write", mem(9'h1), 32'h00000000);
		rd("flags kept", `LCCE_ADR_FLAGS, 32'h00000002);
		wb(1'b1, mem(9'h1), 32'hF731125A);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_AND_INV, 4'h0, 9'h1, 9'h2));
		step(9'h0);
		rd("no result", mem(9'h1), 32'hF731125A);
	endtask

	task automatic sc_call();
		logic [31:0] ret_w;
		wb(1'b1, `LCCE_ADR_FLAGS, 32'h00000000);
		ret_w = ins(`LCCE_OP_JUMP_RET, 4'h1, 9'h0, 9'h0);
		wb(1'b1, mem(9'hA), ret_w);
		wb(1'b1, mem(9'h5), ins(`LCCE_OP_JUMP_RET, 4'h7, 9'hA, 9'h20));
		step(9'h5);
		rd("ret slot", mem(9'hA), {ret_w[31:9], 9'h6});
		rd("call pc", `LCCE_ADR_PC, 32'h00000020);
		rd("call c", `LCCE_ADR_FLAGS, 32'h00000002);
		step(9'hA);
		rd("return pc", `LCCE_ADR_PC, 32'h00000006);
		wb(1'b1, mem(9'h1FF), ins(`LCCE_OP_JUMP_RET, 4'h7, 9'hA, 9'h30));
		step(9'h1FF);
		rd("ret wrap", mem(9'hA), ret_w);
		rd("wrap c", `LCCE_ADR_FLAGS, 32'h00000000);
		wb(1'b1, mem(9'h5), ins(`LCCE_OP_JUMP_RET, 4'h1, 9'hA, 9'h40));
		step(9'h5);
		rd("nr slot", mem(9'hA), ret_w);
		rd("nr pc", `LCCE_ADR_PC, 32'h00000040);
		// Plain call form: result written, immediate, no flag effects
		wb(1'b1, mem(9'h5), ins(`LCCE_OP_JUMP_RET, 4'h3, 9'hA, 9'h50));
		step(9'h5);
		rd("call slot", mem(9'hA), {ret_w[31:9], 9'h6});
		rd("call jump", `LCCE_ADR_PC, 32'h00000050);
		rd("call flags", `LCCE_ADR_FLAGS, 32'h00000000);
	endtask

	task automatic sc_clock();
		logic [31:0] span_ok;
		wb(1'b1, mem(9'h3), 32'hFFFFFF6F);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_HUB, 4'h1, 9'h3, 9'h0));
		step(9'h0);
		span_ok = (busy_cycles >= `LCCE_HUB_MIN_CLK &&
			busy_cycles <= `LCCE_HUB_MAX_CLK) ? 32'h00000001 : 32'h00000000;
		chk("hub clocks", 32'h00000001, span_ok);
		chk("busy low", 32'h00000000, {31'h00000000, busy});
		rd("mode reg", `LCCE_ADR_CLKMODE, 32'h0000006F);
		chk("hub mode", 32'h0000006F, {24'h000000, hub_mode});
		// A nonzero selector is another hub op, not a mode write
		wb(1'b1, mem(9'h3), 32'h00000055);
		wb(1'b1, mem(9'h0), ins(`LCCE_OP_HUB, 4'h1, 9'h3, 9'h1));
		step(9'h0);
		chk("hub kept", 32'h0000006F, {24'h000000, hub_mode});
		chk("hub writes", 32'h00000001, {24'h000000, hub_n});
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		sc_and();
		sc_and_inverted_op();
		sc_call();
		sc_clock();
		tally_and_finish();
	end
endmodule // tb

`default_nettype wire
